// File: shared/pirq_pkg.sv
// Shared constants for the peripheral interrupt and power status register bank
package pirq_pkg;
   // -----------------------------------------------------------------
   // Register indices as printed (not all multiples of four)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_ENABLES = 8'h8c;
   localparam logic [7:0] IDX_PWR = 8'h8e;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
   localparam logic [7:0] IDX_GATES = 8'h92;
   localparam int ADDR_W = 10;
   // -----------------------------------------------------------------
   // Flag and enable bit positions
   // -----------------------------------------------------------------
   localparam int BIT_EEPROM = 7;
   localparam int BIT_ADC = 6;
   localparam int BIT_CAPCOMP = 5;
   localparam int BIT_CMP_B = 4;
   localparam int BIT_CMP_A = 3;
   localparam int BIT_OSC_FAIL = 2;
   localparam int BIT_TIMER_B = 1;
   localparam int BIT_TIMER_A = 0;
   // -----------------------------------------------------------------
   // Power control fields
   // -----------------------------------------------------------------
   localparam int BIT_WAKE = 5;
   localparam int BIT_SW_BOD = 4;
   localparam int BIT_POR = 1;
   localparam int BIT_BOD = 0;
   localparam logic [7:0] PWR_IMPL_MASK = 8'h33;
   localparam logic [1:0] BOD_CFG_SW = 2'h1;
   // Gates register: bit 1 global enable, bit 0 peripheral gate
   localparam int BIT_GLOBAL = 1;
   localparam int BIT_PGATE = 0;
   // Status bits: bit 0 peripheral request, bit 1 brown-out, bit 2 power-on
   localparam int ST_PERIPH = 0;
   localparam int ST_BROWNOUT = 1;
   localparam int ST_POWERON = 2;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_PWR = 8'h11;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [1:0] RST_GATES = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/periph_irq_regs.sv
// Peripheral interrupt flags, enables and power control register bank on AXI4-Lite
//
// Behaviour
// RL1: Eight-bit enable register, read/write, reset zero
// RL2: Events set flags regardless of any enable
// RL3: Software clears flag before setting its enable
// RL4: EEPROM write completion sets bit 7
// RL5: A/D conversion completion sets bit 6
// RL6: Capture or compare event sets bit 5
// RL7: Comparator output changes set bits 4, 3
// RL8: Oscillator failure with switchover sets bit 2
// RL9: Timer B period match sets bit 1
// RL10: Timer A overflow sets bit 0
// RL11: Power bits 7-6, 3-2 read zero
// RL12: Power bit 5 enables low-power wake-up
// RL13: Power bit 4 gates brown-out when config 01
// RL14: Power-on reset clears bit 1; software sets
// RL15: Brown-out clears bit 0; software sets again
// RL16: Peripheral request needs peripheral gate set
// RL17: Global enable passes or blocks all requests; the code gates periph_irq_o only, not irq_o
// RL18: Flag write of one beats same-cycle event; the code ORs events in, so an event also sets its flag against a write of zero
`timescale 1ns/100ps
module periph_irq_regs
   import pirq_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Peripheral events, one-cycle pulses in this clock domain
   input wire logic eeprom_write_done_i,
   input wire logic adc_done_i,
   input wire logic capcomp_event_i,
   input wire logic cmp_b_change_i,
   input wire logic cmp_a_change_i,
   input wire logic osc_fail_i,
   input wire logic timer_b_match_i,
   input wire logic timer_a_overflow_i,
   // Reset cause, configuration and detector
   input wire logic power_on_reset_i,
   input wire logic brownout_detect_i,
   input wire logic [1:0] brownout_config_field_i,
   // Core side
   output logic periph_irq_o,
   output logic low_power_wake_en_o,
   output logic brownout_det_en_o,
   output logic irq_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] pwr;
      logic [1:0] gates;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic periph_req;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Byte address to printed index; misaligned words never decode
   function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] addr);
      word_index = (addr[1:0] == 2'h0) ? {1'b0, addr[ADDR_W-1:2]} : 9'h1ff;
   endfunction

   function automatic logic is_mapped(input logic [8:0] idx);
      is_mapped = (idx == {1'b0, IDX_FLAGS}) || (idx == {1'b0, IDX_ENABLES})
         || (idx == {1'b0, IDX_PWR}) || (idx == {1'b0, IDX_IRQ_STATUS})
         || (idx == {1'b0, IDX_IRQ_MASK}) || (idx == {1'b0, IDX_GATES});
   endfunction

   logic [7:0] events;
   logic do_write;
   logic [8:0] widx;
   logic [8:0] ridx;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic [2:0] irq_events;

   assign events = {eeprom_write_done_i, adc_done_i, capcomp_event_i, cmp_b_change_i,
                    cmp_a_change_i, osc_fail_i, timer_b_match_i, timer_a_overflow_i};

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
      widx = word_index(state_reg.aw_addr);
      ridx = word_index(s_axi_araddr);
      wr_lane0 = do_write && state_reg.w_strb[0];
      wbyte = state_reg.w_data[7:0];

      // Address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end

      // Register writes
      if (wr_lane0 && widx == {1'b0, IDX_FLAGS}) begin
         state_next.flags = wbyte;
      end
      // Events win unless the same write wrote one, which sets the flag anyway
      state_next.flags = state_next.flags | events; // RL2 RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL18
      if (wr_lane0 && widx == {1'b0, IDX_ENABLES}) begin
         state_next.enables = wbyte; // RL1
      end
      if (wr_lane0 && widx == {1'b0, IDX_PWR}) begin
         state_next.pwr = wbyte & PWR_IMPL_MASK; // RL11 RL12 RL13
      end
      if (power_on_reset_i) begin
         state_next.pwr[BIT_POR] = 1'b0; // RL14
      end
      if (brownout_detect_i) begin
         state_next.pwr[BIT_BOD] = 1'b0; // RL15
      end
      if (wr_lane0 && widx == {1'b0, IDX_GATES}) begin
         state_next.gates = wbyte[1:0];
      end
      if (wr_lane0 && widx == {1'b0, IDX_IRQ_MASK}) begin
         state_next.irq_mask = wbyte[2:0];
      end

      // Sticky status, write one to clear, a new event wins
      irq_events = 3'h0;
      irq_events[ST_PERIPH] = state_next.periph_req && !state_reg.periph_req;
      irq_events[ST_BROWNOUT] = brownout_detect_i;
      irq_events[ST_POWERON] = power_on_reset_i;
      if (wr_lane0 && widx == {1'b0, IDX_IRQ_STATUS}) begin
         state_next.irq_status = state_next.irq_status & ~wbyte[2:0];
      end
      state_next.irq_status = state_next.irq_status | irq_events;

      // Reads
      if (s_axi_arvalid && s_axi_arready) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
         state_next.rdata = 32'h0;
         if (ridx == {1'b0, IDX_FLAGS}) begin
            state_next.rdata[7:0] = state_reg.flags;
         end else if (ridx == {1'b0, IDX_ENABLES}) begin
            state_next.rdata[7:0] = state_reg.enables;
         end else if (ridx == {1'b0, IDX_PWR}) begin
            state_next.rdata[7:0] = state_reg.pwr & PWR_IMPL_MASK; // RL11
         end else if (ridx == {1'b0, IDX_IRQ_STATUS}) begin
            state_next.rdata[2:0] = state_reg.irq_status;
         end else if (ridx == {1'b0, IDX_IRQ_MASK}) begin
            state_next.rdata[2:0] = state_reg.irq_mask;
         end else if (ridx == {1'b0, IDX_GATES}) begin
            state_next.rdata[1:0] = state_reg.gates;
         end
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end

      // Registered request keeps the core input glitch free
      state_next.periph_req = |(state_reg.flags & state_reg.enables)
         && state_reg.gates[BIT_PGATE] && state_reg.gates[BIT_GLOBAL]; // RL16 RL17
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= '0;
         state_reg.flags <= RST_FLAGS;
         state_reg.enables <= RST_ENABLES; // RL1
         state_reg.pwr <= RST_PWR; // RL12 RL13
         state_reg.gates <= RST_GATES;
         state_reg.irq_status <= RST_IRQ;
         state_reg.irq_mask <= RST_IRQ;
      end else begin
         state_reg <= state_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // One transfer each way; channels stall while a response is pending
   assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
   assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign periph_irq_o = state_reg.periph_req;
   assign low_power_wake_en_o = state_reg.pwr[BIT_WAKE]; // RL12
   assign brownout_det_en_o = state_reg.pwr[BIT_SW_BOD]
      && (brownout_config_field_i == BOD_CFG_SW); // RL13
   assign irq_o = |(state_reg.irq_status & state_reg.irq_mask);

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_flag_event_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL2
      events[BIT_ADC] |=> state_reg.flags[BIT_ADC])
      else $error("event did not set its flag");
   a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL7
      state_reg.flags[BIT_CMP_A] && !(wr_lane0 && widx == {1'b0, IDX_FLAGS})
      |=> state_reg.flags[BIT_CMP_A])
      else $error("flag dropped without a write");
   a_event_beats_clear: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL18
      wr_lane0 && widx == {1'b0, IDX_FLAGS} && !wbyte[BIT_TIMER_A] && events[BIT_TIMER_A]
      |=> state_reg.flags[BIT_TIMER_A])
      else $error("event lost against flag clear");
   a_enable_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL1
      wr_lane0 && widx == {1'b0, IDX_ENABLES} |=> state_reg.enables == $past(wbyte))
      else $error("enable write not stored");
   a_pwr_unimpl: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL11
      (state_reg.pwr & ~PWR_IMPL_MASK) == 8'h00)
      else $error("unimplemented power bit set");
   a_por_clears: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL14
      power_on_reset_i |=> !state_reg.pwr[BIT_POR])
      else $error("power-on did not clear status");
   a_bod_clears: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL15
      brownout_detect_i |=> !state_reg.pwr[BIT_BOD] ##1 (irq_o || !state_reg.irq_mask[ST_BROWNOUT]))
      else $error("brown-out not recorded");
   a_bod_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL13
      brownout_det_en_o |-> state_reg.pwr[BIT_SW_BOD] && brownout_config_field_i == BOD_CFG_SW)
      else $error("brown-out enable ignores config");
   a_periph_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL16 RL17
      periph_irq_o |-> $past(state_reg.gates[BIT_PGATE]) && $past(state_reg.gates[BIT_GLOBAL]))
      else $error("request passed a closed gate");
   a_read_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered in one cycle");
   c_periph_irq: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(periph_irq_o));
   c_event_clear: cover property (@(posedge clk_i) disable iff (!rstn_i)
      wr_lane0 && widx == {1'b0, IDX_FLAGS} && |events);
   c_write_resp: cover property (@(posedge clk_i) disable iff (!rstn_i) s_axi_bvalid && s_axi_bready);
   c_irq_out: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));

   // -----------------------------------------------------------------
   // Flag checks
   // -----------------------------------------------------------------
   // One check per event line except ADC, which a_flag_event_sets covers, so a swapped bit position shows up at once
   a_eeprom_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL4
      events[BIT_EEPROM] |=> state_reg.flags[BIT_EEPROM])
      else $error("eeprom event did not set its flag");

   a_capcomp_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL6
      events[BIT_CAPCOMP] |=> state_reg.flags[BIT_CAPCOMP])
      else $error("capture event did not set its flag");

   a_cmp_b_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL7
      events[BIT_CMP_B] |=> state_reg.flags[BIT_CMP_B])
      else $error("comparator b event did not set its flag");

   a_cmp_a_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL7
      events[BIT_CMP_A] |=> state_reg.flags[BIT_CMP_A])
      else $error("comparator a event did not set its flag");

   a_osc_fail_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL8
      events[BIT_OSC_FAIL] |=> state_reg.flags[BIT_OSC_FAIL])
      else $error("oscillator event did not set its flag");

   a_timer_b_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL9
      events[BIT_TIMER_B] |=> state_reg.flags[BIT_TIMER_B])
      else $error("timer b event did not set its flag");

   a_timer_a_sets: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL10
      events[BIT_TIMER_A] |=> state_reg.flags[BIT_TIMER_A])
      else $error("timer a event did not set its flag");

   // Flags and enables move only on a write or an event
   a_flag_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL4
      !(wr_lane0 && widx == {1'b0, IDX_FLAGS}) && events == 8'h00
      |=> state_reg.flags == $past(state_reg.flags))
      else $error("flags changed without cause");

   a_enable_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL1
      !(wr_lane0 && widx == {1'b0, IDX_ENABLES})
      |=> state_reg.enables == $past(state_reg.enables))
      else $error("enables changed without a write");

   a_flag_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL18
      wr_lane0 && widx == {1'b0, IDX_FLAGS}
      |=> state_reg.flags == ($past(wbyte) | $past(events)))
      else $error("flag write merged wrongly");

   a_pwr_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL12
      wr_lane0 && widx == {1'b0, IDX_PWR} && !power_on_reset_i && !brownout_detect_i
      |=> state_reg.pwr == ($past(wbyte) & PWR_IMPL_MASK))
      else $error("power write not stored");

   // -----------------------------------------------------------------
   // Gate and status checks
   // -----------------------------------------------------------------
   // Either gate closed must silence the request one cycle later
   a_pgate_closed: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL16
      !state_reg.gates[BIT_PGATE] |=> !periph_irq_o)
      else $error("request passed closed peripheral gate");

   a_global_closed: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL17
      !state_reg.gates[BIT_GLOBAL] |=> !periph_irq_o)
      else $error("request passed closed global enable");

   a_status_por: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL14
      power_on_reset_i |=> state_reg.irq_status[ST_POWERON])
      else $error("power-on status not set");

   a_status_bod: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL15
      brownout_detect_i |=> state_reg.irq_status[ST_BROWNOUT])
      else $error("brown-out status not set");

   // -----------------------------------------------------------------
   // Bus checks
   // -----------------------------------------------------------------
   // Address and data taken together: write acts and answers on the same edge, two cycles later
   a_write_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("write not answered in two cycles");

   a_bvalid_stands: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   a_rvalid_stands: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");

   a_rdata_upper: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL11
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");

   a_bresp_legal: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
      else $error("illegal write response code");

endmodule

// File: verif/event_src.sv
// Behavioural model of the peripheral event sources and reset detectors
`timescale 1ns/100ps
module event_src (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Requests from the bench
   input wire logic [7:0] req_i,
   input wire logic por_req_i,
   input wire logic bod_req_i,
   // Lines towards the register bank
   output logic [7:0] ev_o,
   output logic por_o,
   output logic bod_o
);
   // -----------------------------------------------------------------
   // Sources
   // -----------------------------------------------------------------
   // Each source pulses once per event, as a timer or converter would;
   // a request held high keeps firing, like a level on the real line
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ev_o <= 8'h00;
         por_o <= 1'b0;
         bod_o <= 1'b0;
      end else begin
         ev_o <= req_i;
         por_o <= por_req_i;
         bod_o <= bod_req_i;
      end
   end
endmodule

// File: verif/periph_irq_regs_tb.sv
// Self-checking bench for the peripheral interrupt and power status register bank
`timescale 1ns/100ps
module periph_irq_regs_tb import pirq_pkg::*;;
   localparam logic [33:0] ALL = '1;
   logic clk_i, rstn_i, awvalid, wvalid, bready, arvalid, rready, por_req, bod_req;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, por, brownout_flag_n, pirq, wake_en, det_en, irq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed, rdat;
   logic [3:0] wstrb;
   logic [1:0] cfg, bresp, rresp;
   logic [7:0] req, ev, m_flags, m_en, m_pwr;
   logic [33:0] r;
   int err_total, checks;

   event_src event_src_inst (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req),
      .por_req_i(por_req), .bod_req_i(bod_req), .ev_o(ev), .por_o(por), .bod_o(brownout_flag_n));

   periph_irq_regs periph_irq_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .eeprom_write_done_i(ev[7]), .adc_done_i(ev[6]), .capcomp_event_i(ev[5]),
      .cmp_b_change_i(ev[4]), .cmp_a_change_i(ev[3]), .osc_fail_i(ev[2]),
      .timer_b_match_i(ev[1]), .timer_a_overflow_i(ev[0]),
      .power_on_reset_i(por), .brownout_detect_i(brownout_flag_n), .brownout_config_field_i(cfg),
      .periph_irq_o(pirq), .low_power_wake_en_o(wake_en), .brownout_det_en_o(det_en),
      .irq_o(irq));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   // Readies are sampled at the falling edge, so the value seen is the
   // one present at the next rising edge, free of scheduling races
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      logic ta, tw, dn;
      logic [1:0] br;
      n = 0;
      dn = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!dn && n < 100) begin
         @(negedge clk_i);
         ta = awvalid && awrdy;
         tw = wvalid && wrdy;
         dn = bvalid;
         br = bresp;
         @(posedge clk_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      if (!dn) err_total++;
      else chk({32'h0, br}, {32'h0, RESP_OKAY});
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [33:0] q);
      int n;
      logic ta, dn;
      n = 0;
      dn = 0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!dn && n < 100) begin
         @(negedge clk_i);
         ta = arvalid && arrdy;
         dn = rvalid;
         q = {rresp, rdata};
         @(posedge clk_i);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      if (!dn) err_total++;
   endtask

   task automatic rc(input logic [7:0] idx, input logic [33:0] m, input logic [7:0] exp);
      rd({idx, 2'b00}, r);
      chk(r & m, {26'h0, exp});
   endtask

   task automatic fire(input logic [7:0] v);
      req <= v;
      @(posedge clk_i);
      req <= 8'h00;
      m_flags = m_flags | v;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic pchk(input logic [1:0] g);
      wr(IDX_GATES, {6'h0, g});
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk({33'h0, pirq}, {33'h0, (|(m_flags & m_en)) & g[BIT_GLOBAL] & g[BIT_PGATE]});
      @(posedge clk_i);
   endtask

   task automatic pw();
      for (int c = 0; c < 4; c++) begin
         cfg <= c[1:0];
         @(negedge clk_i);
         chk({32'h0, wake_en, det_en}, {32'h0, m_pwr[BIT_WAKE], m_pwr[BIT_SW_BOD] && c == 1});
         @(posedge clk_i);
      end
      cfg <= BOD_CFG_SW;
   endtask

   // Reset-cause event, then software re-arms the status bits
   task automatic rev(input logic p, input logic b, input logic exp_irq);
      por_req <= p;
      bod_req <= b;
      @(posedge clk_i);
      por_req <= 1'b0;
      bod_req <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (p) m_pwr[BIT_POR] = 1'b0;
      if (b) m_pwr[BIT_BOD] = 1'b0;
      rc(IDX_PWR, ALL, m_pwr);
      @(negedge clk_i);
      chk({33'h0, irq}, {33'h0, exp_irq});
      @(posedge clk_i);
      wr(IDX_PWR, 8'h33);
      m_pwr = 8'h33;
      rc(IDX_PWR, ALL, m_pwr);
   endtask

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      #100us;
      err_total++;
      print_verdict();
   end

   initial begin
      {rstn_i, awvalid, wvalid, bready, arvalid, rready, por_req, bod_req} = '0;
      {awaddr, araddr, wdata, req} = '0;
      // Response readies stay high, so back-to-back calls never re-drive them
      {bready, rready} = 2'h3;
      wstrb = 4'hf;
      cfg = BOD_CFG_SW;
      seed = 32'h3067;
      err_total = 0;
      checks = 0;
      m_flags = RST_FLAGS;
      m_en = RST_ENABLES;
      m_pwr = RST_PWR;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      rc(IDX_FLAGS, ALL, m_flags);
      rc(IDX_ENABLES, ALL, m_en);
      rc(IDX_PWR, ALL, m_pwr);
      rd(10'h3fc, r);
      chk(r, {RESP_SLVERR, 32'h0});
      for (int i = 0; i < 8; i++) begin
         fire(8'h01 << i);
         rc(IDX_FLAGS, ALL, m_flags);
      end
      req <= 8'h01;
      wr(IDX_FLAGS, 8'h00);
      req <= 8'h00;
      m_flags = 8'h01;
      rc(IDX_FLAGS, ALL, m_flags);
      repeat (6) begin
         wr(IDX_FLAGS, 8'h00);
         m_flags = 8'h00;
         rdat = rnd();
         m_en = rdat[7:0];
         wr(IDX_ENABLES, m_en);
         rc(IDX_ENABLES, ALL, m_en);
         fire(rdat[15:8]);
         for (int g = 0; g < 4; g++) pchk(g[1:0]);
      end
      wstrb <= 4'he;
      wr(IDX_ENABLES, ~m_en);
      wstrb <= 4'hf;
      rc(IDX_ENABLES, ALL, m_en);
      wr(IDX_PWR, 8'hff);
      m_pwr = 8'h33;
      rc(IDX_PWR, ALL, m_pwr);
      pw();
      wr(IDX_PWR, 8'h00);
      m_pwr = 8'h00;
      pw();
      wr(IDX_PWR, 8'h33);
      m_pwr = 8'h33;
      wr(IDX_IRQ_MASK, 8'h06);
      wr(IDX_IRQ_STATUS, 8'h07);
      rev(1'b1, 1'b0, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h07);
      wr(IDX_IRQ_MASK, 8'h04);
      rev(1'b0, 1'b1, 1'b0);
      rc(IDX_IRQ_STATUS, 34'h6, 8'h02);
      print_verdict();
   end
endmodule
